// File: hdl/dssl_cfg.svh
// Constants for the drive start/stop and speed select block
// What this block does
// - While jogging, stop commands are ignored; only opening the jog contact or an overload trip stops.
// - All three selector inputs power up with function code 01, no function.
// - Two-wire scheme: run while run/stop contact closed, stop when it opens.
// - Closed analog-selecting input makes the setpoint follow that analog reference.
// - Open analog-selecting input falls back to the standard speed source.
// - Alternate two-wire: run forward while forward contact closed, stop on open.
// - Forward and reverse run contacts both closed means stop.
// - Reverse through selector A only when direction setting allows both ways.
// - Three-wire: start on momentary start closure, stop on momentary stop opening.
// - Three-wire: selector direction change while running waits for the next start; withdrawn permission drops reverse at once.
// - All selectors open means follow the standard speed source.
// - Continuously accumulate a current-squared-times-time heating estimate.
// - At 180 percent current the estimator trips after about 32 seconds.
// - At 150 percent current the estimator trips after about 60 seconds.
// - Never trip while current stays at or below 110 percent.
// - Thermal state clears whenever power is removed.
// - Base frequency limited to 30..129 Hz, maximum to minimum..120 Hz.
// - Seven preset speeds selectable by distinct selector combinations.
// - Among speed selectors closed together, the highest-lettered one wins.
`ifndef DSSL_CFG_SVH
`define DSSL_CFG_SVH

// ************************************************************
// Selector function codes
// ************************************************************
`define DSSL_FN_NONE 8'h01
`define DSSL_FN_V10 8'h02
`define DSSL_FN_MA20 8'h03
`define DSSL_FN_PRESET 8'h04
`define DSSL_FN_RUN_REV 8'h05
`define DSSL_FN_START_REV 8'h06
`define DSSL_FN_JOG_FWD 8'h07
`define DSSL_FN_JOG_REV 8'h08

// ************************************************************
// Debounce timing
// ************************************************************
`define DSSL_CLK_HZ 50000000
`define DSSL_DEBOUNCE_MS 10
`define DSSL_DEBOUNCE_CYC ((`DSSL_CLK_HZ / 1000) * `DSSL_DEBOUNCE_MS)

// ************************************************************
// Overload estimator: current in percent of nominal, one step per ms
// ************************************************************
`define DSSL_OL_TICK_CYC (`DSSL_CLK_HZ / 1000)
`define DSSL_OL_KNEE_PCT 110
`define DSSL_OL_TRIP_180_MS 32000
`define DSSL_OL_TRIP_150_MS 60000
// Heat per ms is I^2 - knee^2; threshold fitted near both trip points
`define DSSL_OL_TRIP_LEVEL 40'h00_269F_B200

// ************************************************************
// Frequency limits in 0.1 Hz
// ************************************************************
`define DSSL_BASE_MIN 16'h012C
`define DSSL_BASE_MAX 16'h050A
`define DSSL_FMAX_MAX 16'h04B0

`endif

// File: hdl/dssl_drive_ctrl.sv
// Start/stop, direction, speed-source and overload logic of the drive
`include "dssl_cfg.svh"
module dssl_drive_ctrl
	import dssl_pkg::*;
#(
	parameter int DEBOUNCE_CYC = `DSSL_DEBOUNCE_CYC,
	parameter int OL_TICK_CYC = `DSSL_OL_TICK_CYC
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire dssl_contacts_s contacts,
	input wire dssl_scheme_e scheme,
	input wire logic fwd_rev_allowed,
	input wire logic [7:0] selector_fn_a,
	input wire logic [7:0] selector_fn_b,
	input wire logic [7:0] selector_fn_c,
	input wire logic selector_fn_load,
	input wire logic stop_cmd,
	input wire logic [7:0] motor_current_pct,
	input wire logic [15:0] base_freq_req,
	input wire logic [15:0] max_freq_req,
	input wire logic [15:0] min_freq,
	output dssl_status_s status,
	output logic [15:0] base_freq,
	output logic [15:0] max_freq,
	output logic [7:0] selector_fn_a_q,
	output logic [7:0] selector_fn_b_q,
	output logic [7:0] selector_fn_c_q
);

	// ************************************************************
	// Contact synchronizers and debounce
	// ************************************************************
	localparam int NC = 5;
	localparam int DBW = $clog2(DEBOUNCE_CYC + 1);
	logic [NC-1:0] sync1;
	logic [NC-1:0] sync2;
	logic [NC-1:0] clean;
	logic [NC-1:0] clean_d;

	genvar gi;
	generate
		for (gi = 0; gi < NC; gi++) begin : g_db
			logic [DBW-1:0] cnt;
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					sync1[gi] <= 1'b0;
					sync2[gi] <= 1'b0;
					clean[gi] <= 1'b0;
					cnt <= '0;
				end else begin
					sync1[gi] <= contacts[gi];
					sync2[gi] <= sync1[gi];
					// Hold-off: accept a level only once it stays for the full window
					if (sync2[gi] == clean[gi]) begin
						cnt <= '0;
					end else if (cnt == DBW'(DEBOUNCE_CYC - 1)) begin
						cnt <= '0;
						clean[gi] <= sync2[gi];
					end else begin
						cnt <= cnt + 1'b1;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			clean_d <= '0;
		end else begin
			clean_d <= clean;
		end
	end

	// Bit order follows the struct: c,b,a,fwd,run from bit 0 upward
	wire sel_c = clean[0];
	wire sel_b = clean[1];
	wire sel_a = clean[2];
	wire fwd_c = clean[3];
	wire run_c = clean[4];
	wire fwd_rise = clean[3] & ~clean_d[3];
	wire run_fall = ~clean[4] & clean_d[4];

	// ************************************************************
	// Selector function codes
	// ************************************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			selector_fn_a_q <= `DSSL_FN_NONE;
			selector_fn_b_q <= `DSSL_FN_NONE;
			selector_fn_c_q <= `DSSL_FN_NONE;
		end else if (selector_fn_load) begin
			selector_fn_a_q <= selector_fn_a;
			selector_fn_b_q <= selector_fn_b;
			selector_fn_c_q <= selector_fn_c;
		end
	end

	wire a_rev_fn = (selector_fn_a_q == `DSSL_FN_RUN_REV) | (selector_fn_a_q == `DSSL_FN_START_REV);
	wire rev_req = a_rev_fn & sel_a & fwd_rev_allowed;
	wire jog_fn = (selector_fn_b_q == `DSSL_FN_JOG_FWD) | (selector_fn_b_q == `DSSL_FN_JOG_REV);
	wire jog_req = jog_fn & sel_b;
	wire jog_rev = (selector_fn_b_q == `DSSL_FN_JOG_REV) & fwd_rev_allowed;

	// ************************************************************
	// Speed source selection, highest letter wins
	// ************************************************************
	function automatic logic is_speed_fn(input logic [7:0] fn);
		is_speed_fn = (fn == `DSSL_FN_V10) | (fn == `DSSL_FN_MA20) | (fn == `DSSL_FN_PRESET);
	endfunction

	function automatic dssl_src_e fn_src(input logic [7:0] fn);
		fn_src = (fn == `DSSL_FN_V10) ? DSSL_SRC_V10 : (fn == `DSSL_FN_MA20) ? DSSL_SRC_MA20 : DSSL_SRC_PRESET;
	endfunction

	wire act_a = sel_a & is_speed_fn(selector_fn_a_q);
	wire act_b = sel_b & is_speed_fn(selector_fn_b_q);
	wire act_c = sel_c & is_speed_fn(selector_fn_c_q);
	wire pre_a = act_a & (selector_fn_a_q == `DSSL_FN_PRESET);
	wire pre_b = act_b & (selector_fn_b_q == `DSSL_FN_PRESET);
	wire pre_c = act_c & (selector_fn_c_q == `DSSL_FN_PRESET);
	// Combination of closed preset selectors names one of seven presets
	wire [2:0] preset_code = {pre_c, pre_b, pre_a};
	wire dssl_src_e analog_src = act_c ? fn_src(selector_fn_c_q) : act_b ? fn_src(selector_fn_b_q) :
		fn_src(selector_fn_a_q);
	wire dssl_src_e next_src = jog_req ? DSSL_SRC_JOG :
		(preset_code != 3'b000) && (analog_src == DSSL_SRC_PRESET) ? DSSL_SRC_PRESET :
		(act_a | act_b | act_c) ? analog_src :
		DSSL_SRC_STANDARD;

	// ************************************************************
	// Overload estimator
	// ************************************************************
	localparam int TKW = $clog2(OL_TICK_CYC + 1);
	logic [TKW-1:0] tick_cnt;
	logic [39:0] heat;
	logic ol_trip;
	wire ol_tick = (tick_cnt == TKW'(OL_TICK_CYC - 1));
	wire [15:0] i_sq = 16'(motor_current_pct) * 16'(motor_current_pct);
	wire [15:0] knee_sq = 16'(`DSSL_OL_KNEE_PCT * `DSSL_OL_KNEE_PCT);
	wire above_knee = i_sq > knee_sq;
	wire [15:0] heat_inc = above_knee ? (i_sq - knee_sq) : 16'h0000;
	wire [15:0] heat_dec = above_knee ? 16'h0000 : (knee_sq - i_sq);
	wire [39:0] heat_add = heat + 40'(heat_inc);
	wire [39:0] next_heat = above_knee ? heat_add : (heat > 40'(heat_dec)) ? heat - 40'(heat_dec) : 40'h00_0000_0000;

	// Reset stands in for power removal: the estimate restarts cold
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt <= '0;
			heat <= '0;
			ol_trip <= 1'b0;
		end else begin
			tick_cnt <= ol_tick ? '0 : tick_cnt + 1'b1;
			if (ol_tick) begin
				heat <= next_heat;
				if (next_heat >= `DSSL_OL_TRIP_LEVEL) begin
					ol_trip <= 1'b1;
				end
			end
		end
	end

	// ************************************************************
	// Run state machine
	// ************************************************************
	dssl_state_e state;
	dssl_state_e next_state;
	logic rev;
	logic next_rev;
	wire two_run = run_c;
	wire alt_fwd = fwd_c & ~(rev_req);
	wire alt_both = fwd_c & a_rev_fn & sel_a;
	wire three_start = fwd_rise & run_c;

	always_comb begin
		next_state = state;
		next_rev = rev;
		unique case (state)
			DSSL_ST_STOP: begin
				if (jog_req) begin
					next_state = DSSL_ST_JOG;
					next_rev = jog_rev;
				end else if (scheme == DSSL_TWO_WIRE && two_run && !stop_cmd) begin
					next_state = DSSL_ST_RUN;
					next_rev = rev_req;
				end else if (scheme == DSSL_ALT_TWO_WIRE && !alt_both && !stop_cmd && (alt_fwd | rev_req)) begin
					next_state = DSSL_ST_RUN;
					next_rev = rev_req;
				end else if (scheme == DSSL_THREE_WIRE && three_start && !stop_cmd) begin
					next_state = DSSL_ST_RUN;
					next_rev = rev_req;
				end
			end
			DSSL_ST_RUN: begin
				if (jog_req) begin
					next_state = DSSL_ST_JOG;
					next_rev = jog_rev;
				end else if (stop_cmd) begin
					next_state = DSSL_ST_STOP;
				end else if (scheme == DSSL_TWO_WIRE) begin
					if (!two_run) begin
						next_state = DSSL_ST_STOP;
					end
				end else if (scheme == DSSL_ALT_TWO_WIRE) begin
					if (alt_both || !(alt_fwd | rev_req)) begin
						next_state = DSSL_ST_STOP;
					end
				end else if (run_fall || !run_c) begin
					next_state = DSSL_ST_STOP;
				end else if (three_start) begin
					next_rev = rev_req;
				end
			end
			DSSL_ST_JOG: begin
				// Stop commands have no effect here; only the jog contact or an overload trip ends it
				if (!jog_req) begin
					next_state = DSSL_ST_STOP;
				end
			end
			DSSL_ST_FAULT: begin
				next_state = DSSL_ST_FAULT;
			end
		endcase
		if (ol_trip) begin
			next_state = DSSL_ST_FAULT;
		end
		// Withdrawn permission drops reverse at once, even in the middle of a run
		if (!fwd_rev_allowed) begin
			next_rev = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= DSSL_ST_STOP;
			rev <= 1'b0;
		end else begin
			state <= next_state;
			rev <= next_rev;
		end
	end

	// ************************************************************
	// Frequency limits and outputs
	// ************************************************************
	wire [15:0] base_lo = (base_freq_req < `DSSL_BASE_MIN) ? `DSSL_BASE_MIN : base_freq_req;
	wire [15:0] next_base = (base_lo > `DSSL_BASE_MAX) ? `DSSL_BASE_MAX : base_lo;
	wire [15:0] fmax_lo = (max_freq_req < min_freq) ? min_freq : max_freq_req;
	wire [15:0] next_fmax = (fmax_lo > `DSSL_FMAX_MAX) ? `DSSL_FMAX_MAX : fmax_lo;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			status <= '0;
			base_freq <= `DSSL_BASE_MIN;
			max_freq <= 16'h0000;
		end else begin
			status.running <= (next_state == DSSL_ST_RUN) | (next_state == DSSL_ST_JOG);
			status.reverse <= next_rev;
			status.speed_src <= next_src;
			status.preset_sel <= preset_code;
			status.overload_fault <= ol_trip;
			base_freq <= next_base;
			max_freq <= next_fmax;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	sequence s_jog_held;
		state == DSSL_ST_JOG && jog_req;
	endsequence

	a_jog_ignores_stop: assert property (@(posedge clock) disable iff (!rst_n)
		s_jog_held ##0 (stop_cmd && !ol_trip) |=> state == DSSL_ST_JOG)
		else $error("Jog stopped by a stop command");
	a_fn_reset_none: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(rst_n) |-> selector_fn_a_q == `DSSL_FN_NONE)
		else $error("Selector code not none after reset");
	a_two_wire_stop: assert property (@(posedge clock) disable iff (!rst_n)
		(scheme == DSSL_TWO_WIRE && state == DSSL_ST_RUN && !run_c && !jog_req) |=> state != DSSL_ST_RUN)
		else $error("Two-wire run did not stop on open contact");
	a_both_stop: assert property (@(posedge clock) disable iff (!rst_n)
		(scheme == DSSL_ALT_TWO_WIRE && alt_both && !jog_req) |=> state != DSSL_ST_RUN)
		else $error("Ran with both direction contacts closed");
	a_rev_needs_perm: assert property (@(posedge clock) disable iff (!rst_n)
		!fwd_rev_allowed |=> !rev)
		else $error("Reverse without permission");
	a_dir_hold: assert property (@(posedge clock) disable iff (!rst_n)
		(scheme == DSSL_THREE_WIRE && state == DSSL_ST_RUN && !three_start && !jog_req && fwd_rev_allowed)
		|=> $stable(rev))
		else $error("Direction changed without start pulse");
	a_std_when_open: assert property (@(posedge clock) disable iff (!rst_n)
		(!sel_a && !sel_b && !sel_c) |=> status.speed_src == DSSL_SRC_STANDARD)
		else $error("Not on standard source with selectors open");
	a_no_trip_low: assert property (@(posedge clock) disable iff (!rst_n)
		(!above_knee && ol_tick && !ol_trip) |=> heat <= $past(heat))
		else $error("Heat rose at or below knee");
	a_trip_faults: assert property (@(posedge clock) disable iff (!rst_n)
		ol_trip |=> state == DSSL_ST_FAULT ##1 status.overload_fault)
		else $error("Overload did not fault");
	a_freq_limits: assert property (@(posedge clock) disable iff (!rst_n)
		##1 (base_freq >= `DSSL_BASE_MIN && base_freq <= `DSSL_BASE_MAX && max_freq <= `DSSL_FMAX_MAX))
		else $error("Frequency setting out of limits");

	sequence s_no_override;
		!jog_req && !stop_cmd && !ol_trip;
	endsequence

	sequence s_three_start;
		scheme == DSSL_THREE_WIRE && state == DSSL_ST_STOP && three_start;
	endsequence

	sequence s_three_run;
		scheme == DSSL_THREE_WIRE && state == DSSL_ST_RUN && run_c;
	endsequence

	// Start, then hold: the two steps of a three-wire run
	a_three_starts: assert property (@(posedge clock) disable iff (!rst_n)
		s_three_start ##0 s_no_override |=> state == DSSL_ST_RUN)
		else $error("Three-wire start pulse did not start");
	a_three_latched: assert property (@(posedge clock) disable iff (!rst_n)
		s_three_run ##0 s_no_override |=> state == DSSL_ST_RUN)
		else $error("Three-wire run not latched");
	a_alt_fwd_runs: assert property (@(posedge clock) disable iff (!rst_n)
		(scheme == DSSL_ALT_TWO_WIRE && state == DSSL_ST_STOP && fwd_c && !sel_a) ##0 s_no_override
		|=> state == DSSL_ST_RUN)
		else $error("Alternate two-wire forward did not run");
	a_analog_follow: assert property (@(posedge clock) disable iff (!rst_n)
		(act_a && !act_b && !act_c && selector_fn_a_q == `DSSL_FN_V10 && !jog_req)
		|=> status.speed_src == DSSL_SRC_V10)
		else $error("Closed analog selector not followed");
	a_c_overrides: assert property (@(posedge clock) disable iff (!rst_n)
		(act_c && act_a && selector_fn_c_q == `DSSL_FN_PRESET && !jog_req)
		|=> status.speed_src == DSSL_SRC_PRESET)
		else $error("Highest selector did not win");
	a_seven_presets: assert property (@(posedge clock) disable iff (!rst_n)
		(pre_a && pre_b && pre_c && !jog_req)
		|=> status.preset_sel == 3'h7 && status.speed_src == DSSL_SRC_PRESET)
		else $error("Preset combination not selected");
	a_heat_rises: assert property (@(posedge clock) disable iff (!rst_n)
		(above_knee && ol_tick) |=> heat > $past(heat))
		else $error("Heat did not rise above the knee");
	a_clean_steady: assert property (@(posedge clock) disable iff (!rst_n)
		(sync2 == clean) |=> $stable(clean))
		else $error("Debounced contacts moved without a new level");

endmodule

// File: hdl/dssl_pkg.sv
// Types for the drive start/stop and speed select block
package dssl_pkg;

	typedef enum logic [1:0] {
		DSSL_TWO_WIRE = 2'b00,
		DSSL_ALT_TWO_WIRE = 2'b01,
		DSSL_THREE_WIRE = 2'b10
	} dssl_scheme_e;

	typedef enum logic [2:0] {
		DSSL_SRC_STANDARD = 3'b000,
		DSSL_SRC_V10 = 3'b001,
		DSSL_SRC_MA20 = 3'b010,
		DSSL_SRC_PRESET = 3'b011,
		DSSL_SRC_JOG = 3'b100
	} dssl_src_e;

	typedef enum logic [1:0] {
		DSSL_ST_STOP = 2'b00,
		DSSL_ST_RUN = 2'b01,
		DSSL_ST_JOG = 2'b10,
		DSSL_ST_FAULT = 2'b11
	} dssl_state_e;

	typedef struct packed {
		logic run_stop_contact;
		logic forward_start_contact;
		logic selector_input_a;
		logic selector_input_b;
		logic selector_input_c;
	} dssl_contacts_s;

	typedef struct packed {
		logic running;
		logic reverse;
		dssl_src_e speed_src;
		logic [2:0] preset_sel;
		logic overload_fault;
	} dssl_status_s;

endpackage

// File: tb/dssl_contact_model.sv
// Behavioural model of the contacts and pushbuttons on the terminal strip
module dssl_contact_model
	import dssl_pkg::*;
(
	input wire logic clock,
	input wire dssl_contacts_s req,
	input wire logic tie_fwd,
	input wire logic bounce,
	output dssl_contacts_s contacts
);
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// Contact chatter
	// ************************************************************
	// A changed contact falls back to its old level for one cycle, shorter than any debounce
	dssl_contacts_s last = '0;
	dssl_contacts_s old = '0;
	logic [1:0] n = 2'd0;
	dssl_contacts_s now_s;
	always @(posedge clock) begin
		if (req != last) begin
			n <= 2'd2;
			old <= last;
		end else if (n != 2'd0) begin
			n <= n - 2'd1;
		end
		last <= req;
	end
	always_comb begin
		now_s = (bounce && n == 2'd1) ? old : req;
		// Installer strap: forward start wired straight to the logic supply
		contacts = now_s;
		contacts.forward_start_contact = now_s.forward_start_contact | tie_fwd;
	end
endmodule

// File: tb/testbench.sv
// Self-checking bench for the drive start/stop and speed select block
`include "dssl_cfg.svh"
module testbench
	import dssl_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	localparam int OLT = 2;
	localparam int T32 = 32000 * OLT;
	localparam logic [7:0] N = `DSSL_FN_NONE;
	localparam logic [7:0] V = `DSSL_FN_V10;
	localparam logic [7:0] M = `DSSL_FN_MA20;
	localparam logic [7:0] P = `DSSL_FN_PRESET;
	localparam logic [7:0] R = `DSSL_FN_RUN_REV;
	typedef struct packed {
		dssl_scheme_e sc;
		logic [4:0] c;
		logic [7:0] fa;
		logic [7:0] fb;
		logic [7:0] fc;
		logic al;
		logic [7:0] ex;
	} dssl_row_s;
	logic clock;
	logic rst_n = 1'b0;
	dssl_contacts_s req = '0;
	dssl_contacts_s contacts;
	logic tie_fwd = 1'b1;
	logic bounce = 1'b0;
	dssl_scheme_e scheme = DSSL_TWO_WIRE;
	logic al = 1'b0;
	logic load = 1'b1;
	logic stop_cmd = 1'b0;
	logic [7:0] fa = N;
	logic [7:0] fb = N;
	logic [7:0] fc = N;
	logic [7:0] cur = 8'h00;
	logic [15:0] bq = 16'h012c;
	logic [15:0] mq = 16'h0258;
	logic [15:0] mn = 16'h0000;
	dssl_status_s status;
	logic [15:0] bf;
	logic [15:0] mf;
	logic [7:0] qa;
	logic [7:0] qb;
	logic [7:0] qc;
	int mismatches = 0;
	int n_checks = 0;
	dssl_row_s rows [17];
	logic [15:0] fq [3][4] = '{'{200, 1300, 300, 1200}, '{1400, 50, 1290, 100}, '{600, 800, 600, 800}};

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	dssl_contact_model model (.clock(clock), .req(req), .tie_fwd(tie_fwd), .bounce(bounce), .contacts(contacts));

	dssl_drive_ctrl #(.DEBOUNCE_CYC(4), .OL_TICK_CYC(OLT)) dut (
		.clock(clock), .rst_n(rst_n), .contacts(contacts), .scheme(scheme), .fwd_rev_allowed(al),
		.selector_fn_a(fa), .selector_fn_b(fb), .selector_fn_c(fc), .selector_fn_load(load),
		.stop_cmd(stop_cmd), .motor_current_pct(cur), .base_freq_req(bq), .max_freq_req(mq),
		.min_freq(mn), .status(status), .base_freq(bf), .max_freq(mf),
		.selector_fn_a_q(qa), .selector_fn_b_q(qb), .selector_fn_c_q(qc)
	);

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// Start button held well past the debounce, then released
	task start_pulse(input logic [4:0] base);
		@(posedge clock);
		req <= base | 5'b01000;
		step(10);
		@(posedge clock);
		req <= base;
		step(12);
	endtask

	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		int i;
		rows[0] = '{DSSL_TWO_WIRE, 5'b11000, N, N, N, 1'b0, 8'b10000000};
		rows[1] = '{DSSL_TWO_WIRE, 5'b01000, N, N, N, 1'b0, 8'b00000000};
		rows[2] = '{DSSL_TWO_WIRE, 5'b11100, V, N, N, 1'b0, 8'b10001000};
		rows[3] = '{DSSL_TWO_WIRE, 5'b11000, V, N, N, 1'b0, 8'b10000000};
		rows[4] = '{DSSL_TWO_WIRE, 5'b11101, V, N, P, 1'b0, 8'b10011100};
		rows[5] = '{DSSL_TWO_WIRE, 5'b11010, N, M, N, 1'b0, 8'b10010000};
		for (i = 1; i < 8; i++)
			rows[5 + i] = '{DSSL_TWO_WIRE, {2'b11, i[0], i[1], i[2]}, P, P, P, 1'b0, {5'b10011, i[2:0]}};
		rows[13] = '{DSSL_ALT_TWO_WIRE, 5'b01000, R, N, N, 1'b1, 8'b10000000};
		rows[14] = '{DSSL_ALT_TWO_WIRE, 5'b01100, R, N, N, 1'b1, 8'b00000000};
		rows[15] = '{DSSL_ALT_TWO_WIRE, 5'b00100, R, N, N, 1'b1, 8'b11000000};
		rows[16] = '{DSSL_ALT_TWO_WIRE, 5'b00100, R, N, N, 1'b0, 8'b00000000};
		step(5);
		check("status in reset", status, 16'h0000);
		check("code a in reset", qa, N);
		check("code b in reset", qb, N);
		check("code c in reset", qc, N);
		@(posedge clock);
		rst_n <= 1'b1;
		for (i = 0; i < 3; i++) begin
			@(posedge clock);
			bq <= fq[i][0];
			mq <= fq[i][1];
			mn <= 16'h0064;
			step(4);
			check("base freq", bf, fq[i][2]);
			check("max freq", mf, fq[i][3]);
		end
		for (i = 0; i < 17; i++) begin
			@(posedge clock);
			scheme <= rows[i].sc;
			tie_fwd <= 1'b0;
			req <= rows[i].c;
			fa <= rows[i].fa;
			fb <= rows[i].fb;
			fc <= rows[i].fc;
			al <= rows[i].al;
			step(12);
			check($sformatf("row %0d", i), status[8:1], rows[i].ex);
		end
		// Jog with a stop command held the whole time
		@(posedge clock);
		scheme <= DSSL_TWO_WIRE;
		tie_fwd <= 1'b1;
		fa <= N;
		fb <= `DSSL_FN_JOG_FWD;
		req <= 5'b00010;
		stop_cmd <= 1'b1;
		step(12);
		check("jog running", status.running, 1'b1);
		check("jog source", status.speed_src, DSSL_SRC_JOG);
		@(posedge clock);
		req <= 5'b00000;
		step(12);
		check("jog released", status.running, 1'b0);
		@(posedge clock);
		stop_cmd <= 1'b0;
		scheme <= DSSL_THREE_WIRE;
		tie_fwd <= 1'b0;
		bounce <= 1'b1;
		fb <= N;
		fa <= `DSSL_FN_START_REV;
		al <= 1'b1;
		req <= 5'b10000;
		step(12);
		check("3w idle", status.running, 1'b0);
		start_pulse(5'b10000);
		check("3w latched", status.running, 1'b1);
		@(posedge clock);
		req <= 5'b10100;
		step(12);
		check("3w dir held", status.reverse, 1'b0);
		start_pulse(5'b10100);
		check("3w dir taken", status.reverse, 1'b1);
		@(posedge clock);
		req <= 5'b00100;
		step(12);
		check("3w stop", status.running, 1'b0);
		// Overload: knee current first, then a long run at 180 percent
		@(posedge clock);
		scheme <= DSSL_TWO_WIRE;
		tie_fwd <= 1'b1;
		bounce <= 1'b0;
		fa <= N;
		req <= 5'b10000;
		cur <= 8'd110;
		step(5000);
		check("no trip at knee", status.overload_fault, 1'b0);
		check("running at knee", status.running, 1'b1);
		@(posedge clock);
		cur <= 8'd180;
		step(T32 - T32 / 16);
		check("early trip", status.overload_fault, 1'b0);
		for (i = 0; i < T32 / 8 && status.overload_fault !== 1'b1; i++)
			step(1);
		if (status.overload_fault !== 1'b1) begin
			mismatches++;
			wrap_up();
		end
		step(3);
		check("trip stops", status.running, 1'b0);
		@(posedge clock);
		rst_n <= 1'b0;
		step(3);
		check("fault cleared", status.overload_fault, 1'b0);
		@(posedge clock);
		rst_n <= 1'b1;
		cur <= 8'd100;
		step(3);
		check("fault after power", status.overload_fault, 1'b0);
		// Codes change only while the load strobe is up
		@(posedge clock);
		load <= 1'b0;
		fa <= R;
		step(3);
		check("code a held", qa, N);
		@(posedge clock);
		load <= 1'b1;
		step(3);
		check("code a loaded", qa, R);
		wrap_up();
	end
endmodule
